// ==== hw/dcmp_event_logic.v ====
// Purpose: control and change-flag logic around two analog comparators
// Assumes: analog cores give raw async outputs; AHB-Lite single word transfers
// Notes: flags are write-one-to-clear; set wins over clear in the same cycle
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dcmp_regs.vh"
module dcmp_event_logic
(
	input wire i_clock,
	input wire i_reset,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output wire [31:0] o_hrdata,
	output wire o_hreadyout,
	output wire o_hresp,
	input wire [1:0] i_core_raw,
	input wire i_total_power_down,
	output wire [1:0] o_core_enable,
	output wire [1:0] o_pos_select,
	output wire [1:0] o_neg_select,
	output reg [1:0] comparator_output_n,
	output wire [1:0] comparator_change_flag_n,
	output wire o_irq
);
	localparam SETTLE_CYCLES = (`DCMP_SETTLE_NS + `DCMP_CLOCK_NS - 1) / `DCMP_CLOCK_NS;

	reg [2:0] cfg0;
	reg [2:0] cfg1;
	reg [1:0] flag;
	reg [2:0] irq_en;
	reg [1:0] sync_a;
	reg [1:0] sync_b;
	reg [1:0] ph_write;
	reg ph_sel;
	reg [3:0] ph_addr;
	reg [31:0] rdata;
	reg tpd_seen;
	wire [1:0] enable;
	wire [1:0] next_out;
	wire [1:0] change;
	wire [1:0] clear;
	wire addr_ok;

	function [31:0] cfg_word;
		input [2:0] cfg;
		input out;
		input flg;
		begin
			cfg_word = 32'h0;
			cfg_word[`DCMP_CFG_EN] = cfg[`DCMP_CFG_EN];
			cfg_word[`DCMP_CFG_POS_SEL] = cfg[`DCMP_CFG_POS_SEL];
			cfg_word[`DCMP_CFG_NEG_SEL] = cfg[`DCMP_CFG_NEG_SEL];
			cfg_word[`DCMP_CFG_OUT] = out;
			cfg_word[`DCMP_CFG_FLAG] = flg;
		end
	endfunction

	assign enable = {cfg1[`DCMP_CFG_EN], cfg0[`DCMP_CFG_EN]} & {2{~i_total_power_down}};
	assign o_core_enable = enable;
	assign o_pos_select = {cfg1[`DCMP_CFG_POS_SEL], cfg0[`DCMP_CFG_POS_SEL]};
	// reference default: select 0 picks bandgap_reference
	assign o_neg_select = {cfg1[`DCMP_CFG_NEG_SEL], cfg0[`DCMP_CFG_NEG_SEL]};

	always @(posedge i_clock)
	begin
		if (i_reset)
		begin
			sync_a <= 2'h3;
			sync_b <= 2'h3;
		end
		else
		begin
			sync_a <= i_core_raw;
			sync_b <= sync_a;
		end
	end

	// output high when greater, forced high when disabled
	assign next_out = sync_b | ~enable;
	// any transition, including the forced rise
	assign change = next_out ^ comparator_output_n;

	always @(posedge i_clock)
	begin
		if (i_reset)
			comparator_output_n <= 2'h3;
		else
			comparator_output_n <= next_out;
	end

	assign addr_ok = ph_addr == `DCMP_ADDR_CFG0 || ph_addr == `DCMP_ADDR_CFG1 ||
		ph_addr == `DCMP_ADDR_IRQ_EN || ph_addr == `DCMP_ADDR_STATUS;
	assign clear[0] = ph_write[0] && ph_addr == `DCMP_ADDR_CFG0 && i_hwdata[`DCMP_CFG_FLAG];
	assign clear[1] = ph_write[0] && ph_addr == `DCMP_ADDR_CFG1 && i_hwdata[`DCMP_CFG_FLAG];

	// flag in configuration register, set wins over clear
	always @(posedge i_clock)
	begin
		if (i_reset)
			flag <= 2'h0;
		else
			flag <= change | (flag & ~clear);
	end
	assign comparator_change_flag_n = flag;

	// AHB-Lite address phase capture
	always @(posedge i_clock)
	begin
		if (i_reset)
		begin
			ph_write <= 2'h0;
			ph_sel <= 1'b0;
			ph_addr <= 4'h0;
		end
		else if (i_hready)
		begin
			ph_sel <= i_hsel && i_htrans == `DCMP_HTRANS_NONSEQ;
			// Upper address bits must be zero, so aliases of the map are ignored
			ph_write <= {1'b0, i_hsel && i_htrans == `DCMP_HTRANS_NONSEQ && i_hwrite &&
				i_haddr[31:4] == `DCMP_ADDR_HI_ZERO};
			ph_addr <= i_haddr[3:0];
		end
		else
			ph_write <= 2'h0;
	end

	// Register writes in the data phase; unmapped addresses ignored
	always @(posedge i_clock)
	begin
		if (i_reset)
		begin
			cfg0 <= `DCMP_CFG_RESET;
			cfg1 <= `DCMP_CFG_RESET;
			irq_en <= `DCMP_IE_RESET;
		end
		else if (ph_write[0] && addr_ok)
		begin
			if (ph_addr == `DCMP_ADDR_CFG0)
				cfg0 <= i_hwdata[2:0];
			if (ph_addr == `DCMP_ADDR_CFG1)
				cfg1 <= i_hwdata[2:0];
			if (ph_addr == `DCMP_ADDR_IRQ_EN)
				irq_en <= i_hwdata[2:0];
		end
	end

	// Sticky total power-down indication, write one to clear
	always @(posedge i_clock)
	begin
		if (i_reset)
			tpd_seen <= 1'b0;
		else if (i_total_power_down)
			tpd_seen <= 1'b1;
		else if (ph_write[0] && ph_addr == `DCMP_ADDR_STATUS && i_hwdata[`DCMP_ST_TPD])
			tpd_seen <= 1'b0;
	end

	// shared request gated by own enable and global gate
	assign o_irq = irq_en[`DCMP_IE_GLOBAL] &&
		((flag[0] && irq_en[`DCMP_IE_CMP0]) || (flag[1] && irq_en[`DCMP_IE_CMP1]));

	// Read data registered during the address phase
	always @(posedge i_clock)
	begin
		if (i_reset)
			rdata <= 32'h0;
		else if (i_hready && i_hsel && i_htrans == `DCMP_HTRANS_NONSEQ && !i_hwrite)
		begin
			if (i_haddr[31:4] != `DCMP_ADDR_HI_ZERO)
				rdata <= 32'h0;
			else
			case (i_haddr[3:0])
				`DCMP_ADDR_CFG0: rdata <= cfg_word(cfg0, next_out[0], flag[0] | change[0]);
				`DCMP_ADDR_CFG1: rdata <= cfg_word(cfg1, next_out[1], flag[1] | change[1]);
				`DCMP_ADDR_IRQ_EN: rdata <= {29'h0, irq_en};
				`DCMP_ADDR_STATUS: rdata <= {30'h0, o_irq, tpd_seen};
				default: rdata <= 32'h0;
			endcase
		end
	end

	assign o_hrdata = rdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
endmodule // dcmp_event_logic
`default_nettype wire

// ==== hw/dcmp_regs.vh ====
// Purpose: register map and constants of the dual comparator event logic
// Assumes: AHB-Lite slave, one aligned 32-bit word per register
// Notes: offsets are byte addresses; upper address bits must be zero
// Operation
// - Output high when positive above negative
// - Positive input two sources, negative pin/reference
// - Reference serves as default negative input
// - Change flag held in configuration register
// - Flag sets on every output transition
// - Disabled comparator output forced high
// - Forced rise sets flag and may interrupt
// - One shared interrupt for both comparators
// - Total power-down disables both comparators
// - Request needs own enable and global gate
`ifndef DCMP_REGS_VH
`define DCMP_REGS_VH
`define DCMP_ADDR_CFG0 4'h0
`define DCMP_ADDR_CFG1 4'h4
`define DCMP_ADDR_IRQ_EN 4'h8
`define DCMP_ADDR_STATUS 4'hC
`define DCMP_ADDR_HI_ZERO 28'h0
// Configuration register fields
`define DCMP_CFG_EN 0
`define DCMP_CFG_POS_SEL 1
`define DCMP_CFG_NEG_SEL 2
`define DCMP_CFG_OUT 3
`define DCMP_CFG_FLAG 4
// Interrupt enable register fields
`define DCMP_IE_CMP0 0
`define DCMP_IE_CMP1 1
`define DCMP_IE_GLOBAL 2
// Status register fields
`define DCMP_ST_TPD 0
`define DCMP_ST_IRQ 1
`define DCMP_CFG_RESET 3'h0
`define DCMP_IE_RESET 3'h0
`define DCMP_HTRANS_NONSEQ 2'h2
`define DCMP_SETTLE_NS 10000
`define DCMP_CLOCK_NS 20
`endif

// ==== tb/dcmp_core_model.sv ====
// Purpose: analog comparator cores
// Assumes: 8-bit levels stand for voltages
// Notes: a disabled core gives a toggling result
`timescale 1ns/1ps
`default_nettype none
module dcmp_core_model #(parameter logic [7:0] BANDGAP = 8'h7B)(
	input wire logic i_clock,
	input wire logic [1:0] i_en,
	input wire logic [1:0] i_ps,
	input wire logic [1:0] i_ns,
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic [7:0] i_n,
	output logic [1:0] o_raw
);
	logic t = 1'b0;
	always @(posedge i_clock)
		t <= !t;
	always_comb
		for (int n = 0; n < 2; n++)
			o_raw[n] = !i_en[n] ? t : (i_ps[n] ? i_b : i_a) > (i_ns[n] ? i_n : BANDGAP);
endmodule // dcmp_core_model
`default_nettype wire

// ==== tb/dcmp_checker.sv ====
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module dcmp_checker(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [1:0] i_core_raw,
	input wire logic i_total_power_down,
	input wire logic [1:0] o_core_enable,
	input wire logic [1:0] comparator_output_n,
	input wire logic [1:0] comparator_change_flag_n,
	input wire logic o_irq
);
	wire [1:0] q = comparator_output_n;
	wire [1:0] f = comparator_change_flag_n;
	wire [1:0] e = o_core_enable;
	wire [1:0] r = i_core_raw;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	chk_flag_zero: assert property ($changed(q[0]) |-> ##[0:1] f[0]) else $error("f0");
	chk_flag_one: assert property ($changed(q[1]) |-> ##[0:1] f[1]) else $error("f1");
	chk_off_zero: assert property (!e[0] [*2] |-> q[0]) else $error("o0");
	chk_off_one: assert property (!e[1] [*2] |-> q[1]) else $error("o1");
	chk_tpd_off: assert property (i_total_power_down |-> e == 2'h0) else $error("tp");
	chk_irq_cause: assert property (o_irq |-> |f) else $error("iq");
	chk_sync_follow: assert property ((e[0] && $stable(r[0])) [*4] |-> q[0] == r[0]) else $error("s0");
	chk_sync_lag: assert property (e[0] [*4] ##0 $changed(r[0]) |=> $stable(q[0])) else $error("s1");
	cover property ($rose(o_irq));
	cover property ($rose(f[1]));
	cover property ($rose(i_total_power_down));
endmodule // dcmp_checker
bind dcmp_event_logic dcmp_checker i_dcmp_checker(.i_clock, .i_reset, .i_core_raw,
	.i_total_power_down, .o_core_enable, .comparator_output_n, .comparator_change_flag_n, .o_irq);
`default_nettype wire

// ==== tb/dual_comparator_event_logic_tb.sv ====
// Purpose: self-checking bench
// Assumes: bus hready is the slave hreadyout
// Notes: bench sets the analog levels
`timescale 1ns/1ps
`default_nettype none
`include "dcmp_regs.vh"
module dual_comparator_event_logic_tb;
	logic c = 0, rs = 1, hw = 0, tp = 0, rdy, irq, rp;
	logic [1:0] ht = 0, en, ps, ns, raw, q, f;
	logic [7:0] pa = 8'hF0, pb = 8'h50, pn = 8'h60;
	logic [31:0] ha = 0, wd = 0, rd;
	int n_fail = 0, n_tests = 0, cyc = 0;
	initial forever #10 c = !c;
	dcmp_event_logic i_dcmp_event_logic(.i_clock(c), .i_reset(rs), .i_hsel(1'b1),
		.i_haddr(ha), .i_htrans(ht), .i_hwrite(hw), .i_hsize(3'h2), .i_hwdata(wd),
		.i_hready(rdy), .o_hrdata(rd), .o_hreadyout(rdy), .o_hresp(rp), .i_core_raw(raw),
		.i_total_power_down(tp), .o_core_enable(en), .o_pos_select(ps), .o_neg_select(ns),
		.comparator_output_n(q), .comparator_change_flag_n(f), .o_irq(irq));
	dcmp_core_model i_dcmp_core_model(.i_clock(c), .i_en(en), .i_ps(ps), .i_ns(ns),
		.i_a(pa), .i_b(pb), .i_n(pn), .o_raw(raw));
	task automatic k(input logic [31:0] v, input logic [31:0] e);
		n_tests++;
		if (v !== e)
		begin
			$display("BAD %0t got %h", $time, v);
			n_fail++;
		end
	endtask
	// Reads compare against d, writes send d
	task automatic x(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge c);
		ha <= a;
		hw <= w;
		ht <= 2'h2;
		do @(posedge c); while (rdy !== 1'b1);
		ht <= 2'h0;
		wd <= d;
		do @(posedge c); while (rdy !== 1'b1);
		if (!w)
			k(rd, d);
	endtask
	task end_of_test;
		$display("checks %0d bad %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge c)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			end_of_test;
		end
	end
	initial
	begin
		repeat (3) @(posedge c);
		rs <= 0;
		x(`DCMP_ADDR_CFG0, 0, 32'h8);
		x(32'h10, 0, 0);
		x(0, 1, 32'h11);
		repeat (`DCMP_SETTLE_NS / `DCMP_CLOCK_NS) @(posedge c);
		x(0, 1, 32'h11);
		x(0, 0, 32'h9);
		pa <= 8'h10;
		repeat (6) @(posedge c);
		x(0, 0, 32'h11);
		x(`DCMP_ADDR_IRQ_EN, 1, 5);
		#1 k(32'(irq), 1);
		x(`DCMP_ADDR_IRQ_EN, 1, 1);
		#1 k(32'(irq), 0);
		$display("t1 done");
		x(0, 1, 32'h11);
		x(`DCMP_ADDR_IRQ_EN, 1, 5);
		x(0, 1, 0);
		repeat (2) @(posedge c);
		#1 k(32'(irq), 1);
		x(0, 0, 32'h18);
		x(0, 1, 32'h10);
		#1 k(32'(irq), 0);
		$display("t2 done");
		x(`DCMP_ADDR_CFG1, 1, 32'h17);
		repeat (`DCMP_SETTLE_NS / `DCMP_CLOCK_NS) @(posedge c);
		x(4, 1, 32'h17);
		x(4, 0, 32'h7);
		pb <= 8'h70;
		repeat (6) @(posedge c);
		x(4, 0, 32'h1F);
		x(8, 1, 6);
		#1 k(32'(irq), 1);
		@(posedge c);
		tp <= 1;
		x(`DCMP_ADDR_STATUS, 0, 32'h3);
		k(32'(en), 0);
		x(8, 1, 4);
		x(4, 1, 0);
		x(4, 1, 32'h10);
		x(4, 0, 32'h8);
		#1 k(32'(irq), 0);
		$display("t3 done");
		end_of_test;
	end
endmodule // dual_comparator_event_logic_tb
`default_nettype wire
